// >>> hw/glp_pkg.sv
`default_nettype none
// ----------------------------------------------------------------------
// shared constants of the level pwm encoder
// ----------------------------------------------------------------------
package glp_pkg;
    // default axi4-lite address width in bits
    localparam int          AXI_ADDR_W   = 12;
    // register indices, byte address is four times the index
    localparam logic [9:0]  PIN2_LL_IDX  = 10'h053;
    localparam logic [9:0]  PIN2_LH_IDX  = 10'h054;
    localparam logic [9:0]  PIN3_LL_IDX  = 10'h055;
    // reset values of the configuration registers
    localparam logic [15:0] LL_RESET     = 16'h007F;
    localparam logic [15:0] LH_RESET     = 16'h3F80;
    // writable bits of the high-level register, top two reserved
    localparam logic [15:0] LH_WMASK     = 16'h3FFF;
    // field positions inside a configuration word
    localparam int          TB_MSB       = 15;
    localparam int          TB_LSB       = 14;
    localparam int          HC_MSB       = 13;
    localparam int          HC_LSB       = 7;
    localparam int          LC_MSB       = 6;
    localparam int          LC_LSB       = 0;
    // tick lengths in master clock periods per selector code
    localparam logic [10:0] TICK_DIV_0   = 11'h010;
    localparam logic [10:0] TICK_DIV_1   = 11'h040;
    localparam logic [10:0] TICK_DIV_2   = 11'h100;
    localparam logic [10:0] TICK_DIV_3   = 11'h400;
    // axi response codes
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    // waveform phases, gray along static -> high -> low
    typedef enum logic [1:0] {
        GLP_STATIC = 2'h0,
        GLP_HIGH   = 2'h1,
        GLP_LOW    = 2'h3
    } glp_phase_e;
endpackage
`default_nettype wire

// >>> hw/glp_top.sv
`timescale 1ns/1ns
`default_nettype none
// Contract
// - selector codes pick 16/64/256/1024 clock ticks
// - one selected tick drives pin pwm
// - period is high plus low ticks
// - high phase lasts high-count ticks
// - low phase lasts low-count ticks
// - zero high count gives static low
// - zero low count gives static high
// - both counts zero gives static low
// - pin level picks which counter pair
// - pin2 low-level register 53h reset 007Fh
// - pin2 high-level register 54h reset 3F80h
// - pin3 low-level register 55h reset 007Fh
module glp_top #(
    parameter int ADDR_W = glp_pkg::AXI_ADDR_W  // axi address width
) (
    input  wire logic              sys_clk,       // master clock, 100 MHz
    input  wire logic              rst_n,         // synchronous reset, active low
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,  // write address
    input  wire logic              s_axi_awvalid, // write address valid
    output logic                   s_axi_awready, // write address ready
    input  wire logic [31:0]       s_axi_wdata,   // write data
    input  wire logic [3:0]        s_axi_wstrb,   // write byte enables
    input  wire logic              s_axi_wvalid,  // write data valid
    output logic                   s_axi_wready,  // write data ready
    output logic [1:0]             s_axi_bresp,   // write response
    output logic                   s_axi_bvalid,  // write response valid
    input  wire logic              s_axi_bready,  // write response ready
    input  wire logic [ADDR_W-1:0] s_axi_araddr,  // read address
    input  wire logic              s_axi_arvalid, // read address valid
    output logic                   s_axi_arready, // read address ready
    output logic [31:0]            s_axi_rdata,   // read data
    output logic [1:0]             s_axi_rresp,   // read response
    output logic                   s_axi_rvalid,  // read data valid
    input  wire logic              s_axi_rready,  // read data ready
    input  wire logic              pin2_level,    // programmed level of the fault-shared pin
    input  wire logic              pin3_level,    // programmed level of the next pin
    output logic                   pin2_out,      // encoded waveform, fault-shared pin
    output logic                   pin3_out       // encoded waveform, next pin
);
    import glp_pkg::*;

    // ------------------------------------------------------------------
    // register file and bus state
    // ------------------------------------------------------------------
    logic [15:0]       pin2_low_level_pwm_config;       // pin2 low-level word
    logic [15:0]       pin2_high_level_pwm_config;      // pin2 high-level word
    logic [15:0]       pin3_low_level_pwm_config;       // pin3 low-level word
    logic [15:0]       next_pin2_low_level_pwm_config;  // next pin2 low-level word
    logic [15:0]       next_pin2_high_level_pwm_config; // next pin2 high-level word
    logic [15:0]       next_pin3_low_level_pwm_config;  // next pin3 low-level word
    logic              aw_got;                          // write address held
    logic              w_got;                           // write data held
    logic              next_aw_got;                     // next address held
    logic              next_w_got;                      // next data held
    logic [ADDR_W-1:0] aw_addr;                         // held write address
    logic [ADDR_W-1:0] next_aw_addr;                    // next held address
    logic [31:0]       w_data;                          // held write data
    logic [31:0]       next_w_data;                     // next held data
    logic [3:0]        w_strb;                          // held byte enables
    logic [3:0]        next_w_strb;                     // next byte enables
    logic              next_awready;                    // next awready
    logic              next_wready;                     // next wready
    logic              next_bvalid;                     // next bvalid
    logic [1:0]        next_bresp;                      // next bresp
    logic              next_arready;                    // next arready
    logic              next_rvalid;                     // next rvalid
    logic [31:0]       next_rdata;                      // next rdata
    logic [1:0]        next_rresp;                      // next rresp
    logic [9:0]        w_idx;                           // word index of write
    logic [9:0]        r_idx;                           // word index of read

    assign w_idx = 10'(aw_addr[ADDR_W-1:2]);
    assign r_idx = 10'(s_axi_araddr[ADDR_W-1:2]);

    // merge the enabled byte lanes of a write into a 16-bit word
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
        logic [15:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction

    // ------------------------------------------------------------------
    // axi4-lite write and read channels
    // ------------------------------------------------------------------
    // address and data are taken in either order; response follows both
    always_comb begin
        next_aw_got  = aw_got;
        next_w_got   = w_got;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        next_pin2_low_level_pwm_config  = pin2_low_level_pwm_config;
        next_pin2_high_level_pwm_config = pin2_high_level_pwm_config;
        next_pin3_low_level_pwm_config  = pin3_low_level_pwm_config;
        // capture address
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_got  = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        // capture data
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_got  = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        // retire a taken response
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        // both halves held: commit the write
        if (aw_got && w_got && !s_axi_bvalid) begin
            next_aw_got = 1'b0;
            next_w_got  = 1'b0;
            next_bvalid = 1'b1;
            next_bresp  = RESP_OKAY;
            case (w_idx)
                PIN2_LL_IDX: begin
                    next_pin2_low_level_pwm_config =
                        merge16(pin2_low_level_pwm_config, w_data, w_strb);
                end
                PIN2_LH_IDX: begin
                    next_pin2_high_level_pwm_config =
                        merge16(pin2_high_level_pwm_config, w_data, w_strb) & LH_WMASK;
                end
                PIN3_LL_IDX: begin
                    next_pin3_low_level_pwm_config =
                        merge16(pin3_low_level_pwm_config, w_data, w_strb);
                end
                // unmapped: nothing stored, error answered
                default: begin
                    next_bresp = RESP_SLVERR;
                end
            endcase
        end
        // one write at a time: each ready only while its own half is not held and no response is pending
        next_awready = !next_aw_got && !next_bvalid;
        next_wready  = !next_w_got && !next_bvalid;
    end

    // read answers one cycle after the address is taken
    always_comb begin
        next_rvalid  = s_axi_rvalid;
        next_rdata   = s_axi_rdata;
        next_rresp   = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OKAY;
            case (r_idx)
                PIN2_LL_IDX: next_rdata = {16'h0000, pin2_low_level_pwm_config};
                PIN2_LH_IDX: next_rdata = {16'h0000, pin2_high_level_pwm_config};
                PIN3_LL_IDX: next_rdata = {16'h0000, pin3_low_level_pwm_config};
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end
        next_arready = !next_rvalid;
    end

    // register the bus and configuration state
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            aw_addr       <= '0;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
            pin2_low_level_pwm_config  <= LL_RESET;
            pin2_high_level_pwm_config <= LH_RESET;
            pin3_low_level_pwm_config  <= LL_RESET;
        end else begin
            aw_got        <= next_aw_got;
            w_got         <= next_w_got;
            aw_addr       <= next_aw_addr;
            w_data        <= next_w_data;
            w_strb        <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
            pin2_low_level_pwm_config  <= next_pin2_low_level_pwm_config;
            pin2_high_level_pwm_config <= next_pin2_high_level_pwm_config;
            pin3_low_level_pwm_config  <= next_pin3_low_level_pwm_config;
        end
    end

    // ------------------------------------------------------------------
    // per-pin waveform generators
    // ------------------------------------------------------------------
    // pin3 has no high-level register here, so its high level stays static high
    logic [15:0] ch_ll  [2];  // low-level word per pin
    logic [15:0] ch_lh  [2];  // high-level word per pin
    logic        ch_lvl [2];  // programmed level per pin
    logic        ch_out [2];  // waveform flop per pin

    assign ch_ll[0]  = pin2_low_level_pwm_config;
    assign ch_ll[1]  = pin3_low_level_pwm_config;
    assign ch_lh[0]  = pin2_high_level_pwm_config;
    assign ch_lh[1]  = LH_RESET;
    assign ch_lvl[0] = pin2_level;
    assign ch_lvl[1] = pin3_level;
    assign pin2_out  = ch_out[0];
    assign pin3_out  = ch_out[1];

    for (genvar g = 0; g < 2; g++) begin : g_ch
        glp_phase_e  phase;       // current phase
        glp_phase_e  next_phase;  // next phase
        logic [10:0] pre;         // prescaler count within a tick
        logic [10:0] next_pre;    // next prescaler count
        logic [6:0]  cnt;         // ticks left in the phase
        logic [6:0]  next_cnt;    // next ticks left
        logic [1:0]  tb;          // tick select latched at boundary
        logic [1:0]  next_tb;     // next latched tick select
        logic [6:0]  lc;          // low count latched at boundary
        logic [6:0]  next_lc;     // next latched low count
        logic        next_out;    // next waveform level
        logic [15:0] sel;         // word chosen by the pin level
        logic [10:0] div;         // tick length in clocks
        logic        tick;        // last clock of a tick
        logic        boundary;    // period ends this cycle

        // current level picks its counter pair
        assign sel = ch_lvl[g] ? ch_lh[g] : ch_ll[g];

        always_comb begin
            case (tb)
                2'h0:    div = TICK_DIV_0;
                2'h1:    div = TICK_DIV_1;
                2'h2:    div = TICK_DIV_2;
                default: div = TICK_DIV_3;
            endcase
        end

        // one tick serves both phases of the pin
        assign tick     = (pre == div - 11'h001);
        // period closes after the low phase
        assign boundary = (phase == GLP_STATIC) ||
                          (phase == GLP_LOW && tick && cnt == 7'h01);

        // phase sequencing; static levels re-evaluate every clock
        always_comb begin
            next_phase = phase;
            next_pre   = pre;
            next_cnt   = cnt;
            next_tb    = tb;
            next_lc    = lc;
            next_out   = ch_out[g];
            // running phases count ticks
            if (phase != GLP_STATIC) begin
                next_pre = tick ? 11'h000 : pre + 11'h001;
                if (tick) begin
                    next_cnt = cnt - 7'h01;
                end
            end
            // high done, low lasts latched count
            if (phase == GLP_HIGH && tick && cnt == 7'h01) begin
                next_phase = GLP_LOW;
                next_cnt   = lc;
                next_out   = 1'b0;
            end
            if (boundary) begin
                next_pre = 11'h000;
                next_tb  = sel[TB_MSB:TB_LSB];
                next_lc  = sel[LC_MSB:LC_LSB];
                if (sel[HC_MSB:HC_LSB] == 7'h00) begin
                    next_phase = GLP_STATIC;
                    next_out   = 1'b0;
                end else if (sel[LC_MSB:LC_LSB] == 7'h00) begin
                    next_phase = GLP_STATIC;
                    next_out   = 1'b1;
                end else begin
                    next_phase = GLP_HIGH;
                    next_cnt   = sel[HC_MSB:HC_LSB];
                    next_out   = 1'b1;
                end
            end
        end

        // register the generator state
        always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
                phase     <= GLP_STATIC;
                pre       <= 11'h000;
                cnt       <= 7'h00;
                tb        <= 2'h0;
                lc        <= 7'h00;
                ch_out[g] <= 1'b0;
            end else begin
                phase     <= next_phase;
                pre       <= next_pre;
                cnt       <= next_cnt;
                tb        <= next_tb;
                lc        <= next_lc;
                ch_out[g] <= next_out;
            end
        end
    end

endmodule // glp_top
`default_nettype wire

// >>> dv/glp_top_sva.sv
`timescale 1ns/1ns
`default_nettype none
module glp_top_sva
    import glp_pkg::*;
#(
    parameter int ADDR_W = 12 // axi address width
) (
    input wire logic              sys_clk,       // master clock
    input wire logic              rst_n,         // sync reset, active low
    input wire logic              s_axi_awvalid, // aw valid
    input wire logic              s_axi_awready, // aw ready
    input wire logic              s_axi_wvalid,  // w valid
    input wire logic              s_axi_wready,  // w ready
    input wire logic [1:0]        s_axi_bresp,   // write response code
    input wire logic              s_axi_bvalid,  // b valid
    input wire logic              s_axi_bready,  // b ready
    input wire logic [ADDR_W-1:0] s_axi_araddr,  // read address
    input wire logic              s_axi_arvalid, // ar valid
    input wire logic              s_axi_arready, // ar ready
    input wire logic [31:0]       s_axi_rdata,   // read data
    input wire logic [1:0]        s_axi_rresp,   // read response code
    input wire logic              s_axi_rvalid,  // r valid
    input wire logic              s_axi_rready   // r ready
);
    // ------------------------------------------------------------
    // helper: address of the read under way
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] rd_addr;      // kept until the answer leaves
    logic [ADDR_W-1:0] next_rd_addr; // captured at the ar handshake
    logic              rd_mapped;    // read hits one of three words
    // capture only on a handshake, so a stalled ar cannot move it
    always_comb begin
        next_rd_addr = rd_addr;
        if (s_axi_arvalid && s_axi_arready) next_rd_addr = s_axi_araddr;
    end
    // register the capture
    always_ff @(posedge sys_clk) begin
        rd_addr <= next_rd_addr;
    end
    assign rd_mapped = (rd_addr == ADDR_W'({PIN2_LL_IDX, 2'h0}))
                    || (rd_addr == ADDR_W'({PIN2_LH_IDX, 2'h0}))
                    || (rd_addr == ADDR_W'({PIN3_LL_IDX, 2'h0}));
    // ------------------------------------------------------------
    // bus properties
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (s_wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer not two cycles after handshake");
    a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
        else $error("read answer not one cycle after handshake");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer dropped or changed while stalled");
    a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped or changed while stalled");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer pending");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    a_reserved_zero: assert property (s_axi_rvalid &&
        rd_addr == ADDR_W'({PIN2_LH_IDX, 2'h0}) |-> s_axi_rdata[15:14] == 2'h0)
        else $error("reserved bits of high-level word not zero");
    a_unmapped_err: assert property (s_axi_rvalid && !rd_mapped |->
        s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_mapped_okay: assert property (s_axi_rvalid && rd_mapped |-> s_axi_rresp == RESP_OKAY)
        else $error("mapped read refused");
endmodule // glp_top_sva
`default_nettype wire

// >>> dv/glp_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module glp_top_bench;
    import glp_pkg::*;
    localparam logic [11:0] A_LL2 = {PIN2_LL_IDX, 2'h0}; // byte address is four times index
    localparam logic [11:0] A_LH2 = {PIN2_LH_IDX, 2'h0};
    localparam logic [11:0] A_LL3 = {PIN3_LL_IDX, 2'h0};
    logic        sys_clk, rst_n, pin2_level, pin3_level;       // clock, reset, levels
    logic [11:0] s_axi_awaddr, s_axi_araddr;                  // bus addresses
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;    // write side strobes
    logic        s_axi_arvalid, s_axi_rready;                  // read side strobes
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;                 // data words
    logic [3:0]  s_axi_wstrb;                                  // byte enables
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;    // design answers
    logic        s_axi_arready, s_axi_rvalid, pin2_out, pin3_out;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;                  // response codes
    int          n_errors, cmp_count, cycles, seed, hi, lo, hc, lc, bad;
    logic [31:0] stat_cfg [3] = '{32'h0005, 32'h0180, 32'h0000}; // hc0, lc0, both 0
    logic        stat_exp [3] = '{1'b0, 1'b1, 1'b0};
    glp_top uut (
        .sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .pin2_level(pin2_level), .pin3_level(pin3_level),
        .pin2_out(pin2_out), .pin3_out(pin3_out));
    // ------------------------------------------------------------
    // clock, watchdog, verdict
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // longest pwm test runs at most about 19k cycles, 90k means a hang
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            n_errors++;
            summarize();
        end
    end
    task automatic summarize;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_len(input int got, input int exp);
        cmp_count++;
        if (got != exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // expected tick length and config word, worked out here
    function automatic int tick(input int code);
        return 16 << (2 * code);
    endfunction
    function automatic logic [31:0] cfg(input int tb, input int h, input int l);
        return {16'h0, tb[1:0], h[6:0], l[6:0]};
    endfunction
    function automatic logic pin_of(input bit sel);
        return sel ? pin3_out : pin2_out;
    endfunction
    // ------------------------------------------------------------
    // bus master: valid held until its own ready edge
    // ------------------------------------------------------------
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rs);
        @(posedge sys_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
        @(posedge sys_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // one full period from a rising boundary; flip_at toggles the level mid-high
    task automatic measure(input bit sel, input int flip_at, output int h, output int l);
        h = 0;
        l = 0;
        @(posedge sys_clk);
        while (pin_of(sel) !== 1'b0) @(posedge sys_clk);
        while (pin_of(sel) !== 1'b1) @(posedge sys_clk);
        while (pin_of(sel) === 1'b1) begin
            h++;
            if (h == flip_at) pin2_level <= ~pin2_level;
            @(posedge sys_clk);
        end
        while (pin_of(sel) === 1'b0) begin
            l++;
            @(posedge sys_clk);
        end
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {n_errors, cmp_count, cycles} = '0;
        seed = 32'h2f45;
        {rst_n, pin2_level, pin3_level, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        axi_read(A_LL2, rd, r);
        check_word(rd, 32'h007F);
        axi_read(A_LH2, rd, r);
        check_word(rd, 32'h3F80);
        axi_read(A_LL3, rd, r);
        check_word(rd, 32'h007F);
        axi_read(12'h158, rd, r);
        check_word(rd, 32'h0);
        check_word(32'(r), 32'h2);
        axi_write(12'h158, 32'hFFFF, r);
        check_word(r, 2'h2);
        axi_write(A_LH2, 32'hFFFF_FFFF, r);
        axi_read(A_LH2, rd, r);
        check_word(rd, 32'h3FFF);
        axi_write(A_LH2, 32'h3F80, r);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            pin2_level <= i[0];
            pin3_level <= i[1];
            repeat (3) @(posedge sys_clk);
            check_word(pin2_out, i[0]);
            check_word(pin3_out, i[1]);
        end
        pin2_level <= 1'b0;
        pin3_level <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            axi_write(A_LL2, stat_cfg[i], r);
            repeat (3) @(posedge sys_clk);
            bad = 0;
            repeat (40) @(posedge sys_clk) bad += (pin2_out !== stat_exp[i]);
            check_len(bad, 0);
        end
        $display("test static levels done");
        for (int c = 0; c < 5; c++) begin
            hc = (c == 4) ? 127 : 1 + {$random(seed)} % 3;
            lc = (c == 4) ? 1 : 1 + {$random(seed)} % 3;
            axi_write(A_LL2, cfg(c % 4, hc, lc), r);
            measure(1'b0, 0, hi, lo);
            check_len(hi, hc * tick(c % 4));
            check_len(lo, lc * tick(c % 4));
        end
        axi_write(A_LL3, cfg(1, 2, 1), r);
        measure(1'b1, 0, hi, lo);
        check_len(hi + lo, 3 * 64);
        $display("test pwm timing done");
        axi_write(A_LH2, cfg(0, 1, 1), r);
        axi_write(A_LL2, cfg(0, 2, 2), r);
        measure(1'b0, 5, hi, lo);
        check_len(hi + lo, 64);
        measure(1'b0, 0, hi, lo);
        check_len(hi * 100 + lo, 1616);
        $display("test level switch done");
        summarize();
    end
endmodule // glp_top_bench
bind glp_top glp_top_sva #(.ADDR_W(ADDR_W)) u_sva (
    .sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire
